// ### rtucrc_map.svh
// constants of the rtu crc-16 generator and checker
`ifndef RTUCRC_MAP_SVH
`define RTUCRC_MAP_SVH

// remainder preset at the start of every message
`define RTUCRC_PRESET      16'hFFFF
// full generator x^16 + x^15 + x^2 + 1
`define RTUCRC_POLY_FULL   17'h18005
// shift steps per byte
`define RTUCRC_SHIFTS      4'h8
// check characters appended or received per frame
`define RTUCRC_CHK_BYTES   2
// remainder value of an error-free frame
`define RTUCRC_GOOD        16'h0000
// frame byte counter first value
`define RTUCRC_CNT_FIRST   1

`endif

// ### rtucrc_pkg.sv
// types of the rtu crc-16 generator and checker
`default_nettype none

package rtucrc_pkg;

    // one byte on the framer side; valid for one cycle on input, held until taken on the check output
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rtucrc_byte_t;

    // frame status toward the framer
    typedef struct packed {
        logic done;
        logic ok;
        logic err;
        logic overrun;
        logic busy;
    } rtucrc_stat_t;

    typedef enum logic [2:0] {
        RTUCRC_IDLE   = 3'b000,
        RTUCRC_DATA   = 3'b001,
        RTUCRC_WAIT   = 3'b010,
        RTUCRC_CHK_LO = 3'b011,
        RTUCRC_CHK_HI = 3'b100,
        RTUCRC_DONE   = 3'b101
    } rtucrc_state_t;

endpackage

`default_nettype wire

// ### rtucrc_engine.sv
// byte-wise crc-16 shift engine, one shift step per clock
`timescale 1ns/1ps
`default_nettype none
`include "rtucrc_map.svh"

module rtucrc_engine
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        preset_in,
    input  wire logic        start_in,
    input  wire logic [7:0]  byte_in,
    output var  logic        busy_out,
    output var  logic        done_out,
    output var  logic        zero_out,
    output var  logic [15:0] crc_out
);

    // reflected form of the generator, x^16 dropped
    function automatic logic [15:0] refl_poly(input logic [16:0] full);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++)
        begin
            r[15 - i] = full[i];
        end
        return r;
    endfunction

    localparam logic [15:0] POLY = refl_poly(`RTUCRC_POLY_FULL);

    // one serial step: in ^ lsb feeds bits 15, 13 and 0
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din);
        logic fb;
        fb = crc[0] ^ din;
        return (crc >> 1) ^ (fb ? POLY : 16'h0000);
    endfunction

    logic [15:0] crc_q,  crc_d;
    logic [3:0]  cnt_q,  cnt_d;
    logic        busy_q, busy_d;
    logic        done_q, done_d;
    logic        zero_q, zero_d;

    always_comb
    begin
        crc_d  = crc_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (preset_in)
        begin
            crc_d  = `RTUCRC_PRESET;
            cnt_d  = 4'h0;
            busy_d = 1'b0;
        end
        else if (start_in && !busy_q)
        begin
            // byte lands in the low half, the reflected high-order byte
            crc_d  = crc_q ^ {8'h00, byte_in};
            cnt_d  = 4'h0;
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            crc_d = crc_step(crc_q, 1'b0);
            cnt_d = cnt_q + 4'h1;
            if (cnt_d == `RTUCRC_SHIFTS)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
        zero_d = (crc_d == `RTUCRC_GOOD);
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            crc_q  <= `RTUCRC_PRESET;
            cnt_q  <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else
        begin
            crc_q  <= crc_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
            zero_q <= zero_d;
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;
    assign zero_out = zero_q;
    assign crc_out  = crc_q;

endmodule // rtucrc_engine

`default_nettype wire

// ### rtucrc_top.sv
// rtu crc-16 generator and checker facing the message framer
`timescale 1ns/1ps
`default_nettype none
`include "rtucrc_map.svh"

module rtucrc_top
#(
    parameter int LEN_W = 8
)
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  preset_in,
    input  wire logic                  mode_rx_in,
    input  wire logic [LEN_W-1:0]      data_len_in,
    input  wire rtucrc_pkg::rtucrc_byte_t byte_in,
    output var  logic                  byte_ready_out,
    output var  rtucrc_pkg::rtucrc_byte_t chk_out,
    input  wire logic                  chk_ready_in,
    output var  logic [15:0]           crc_out,
    output var  logic                  crc_zero_out,
    output var  rtucrc_pkg::rtucrc_stat_t status_out
);

    localparam int CNT_W = LEN_W + 2;

    // frame length in bytes that pass through the engine
    function automatic logic [CNT_W-1:0] frame_len(input logic [LEN_W-1:0] len,
                                                   input logic rx);
        logic [CNT_W-1:0] n;
        n = {2'b00, len};
        if (rx)
        begin
            // received check bytes run through the same division
            n = n + CNT_W'(`RTUCRC_CHK_BYTES);
        end
        return n;
    endfunction

    rtucrc_pkg::rtucrc_state_t state_q, state_d;

    logic [CNT_W-1:0] cnt_q,     cnt_d;
    logic [CNT_W-1:0] len_q,     len_d;
    logic             rx_q,      rx_d;
    logic [7:0]       hi_q,      hi_d;
    logic [7:0]       out_q,     out_d;
    logic             done_q,    done_d;
    logic             ok_q,      ok_d;
    logic             err_q,     err_d;
    logic             ovr_q,     ovr_d;
    logic             start;
    logic             data_end;
    logic             eng_busy;
    logic             eng_done;
    logic             eng_zero;
    logic [15:0]      eng_crc;

    rtucrc_engine u_engine
    (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .preset_in  (preset_in),
        .start_in   (start),
        .byte_in    (byte_in.data),
        .busy_out   (eng_busy),
        .done_out   (eng_done),
        .zero_out   (eng_zero),
        .crc_out    (eng_crc)
    );

    // counting from one, the frame is over once the count passes its length
    assign data_end = (cnt_q > len_q);

    // bytes arrive in frame order; the framer owns the field sequence
    assign byte_ready_out = (state_q == rtucrc_pkg::RTUCRC_DATA) && !data_end;

    // one byte per valid strobe, never while shifting
    assign start = byte_ready_out && byte_in.valid && !preset_in;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        len_d   = len_q;
        rx_d    = rx_q;
        hi_d    = hi_q;
        out_d   = out_q;
        done_d  = 1'b0;
        ok_d    = ok_q;
        err_d   = err_q;
        ovr_d   = ovr_q;
        if (preset_in)
        begin
            state_d = rtucrc_pkg::RTUCRC_DATA;
            cnt_d   = CNT_W'(`RTUCRC_CNT_FIRST);
            len_d   = frame_len(data_len_in, mode_rx_in);
            rx_d    = mode_rx_in;
            ok_d    = 1'b0;
            err_d   = 1'b0;
            ovr_d   = 1'b0;
        end
        else
        begin
            // a strobe that finds the block busy is dropped, and flagged
            if (byte_in.valid && !start && state_q != rtucrc_pkg::RTUCRC_IDLE)
            begin
                ovr_d = 1'b1;
            end
            unique case (state_q)
                rtucrc_pkg::RTUCRC_IDLE:
                begin
                    state_d = rtucrc_pkg::RTUCRC_IDLE;
                end
                rtucrc_pkg::RTUCRC_DATA:
                begin
                    if (data_end)
                    begin
                        if (rx_q)
                        begin
                            state_d = rtucrc_pkg::RTUCRC_DONE;
                            done_d  = 1'b1;
                            ok_d    = eng_zero;
                            err_d   = !eng_zero;
                        end
                        else
                        begin
                            // low byte first puts the reflected msb first on the wire
                            state_d = rtucrc_pkg::RTUCRC_CHK_LO;
                            out_d   = eng_crc[7:0];
                            hi_d    = eng_crc[15:8];
                        end
                    end
                    else if (start)
                    begin
                        state_d = rtucrc_pkg::RTUCRC_WAIT;
                    end
                end
                rtucrc_pkg::RTUCRC_WAIT:
                begin
                    if (eng_done)
                    begin
                        cnt_d   = cnt_q + CNT_W'(1);
                        state_d = rtucrc_pkg::RTUCRC_DATA;
                    end
                end
                rtucrc_pkg::RTUCRC_CHK_LO:
                begin
                    if (chk_ready_in)
                    begin
                        state_d = rtucrc_pkg::RTUCRC_CHK_HI;
                        out_d   = hi_q;
                    end
                end
                rtucrc_pkg::RTUCRC_CHK_HI:
                begin
                    if (chk_ready_in)
                    begin
                        state_d = rtucrc_pkg::RTUCRC_DONE;
                        done_d  = 1'b1;
                        ok_d    = 1'b1;
                    end
                end
                rtucrc_pkg::RTUCRC_DONE:
                begin
                    state_d = rtucrc_pkg::RTUCRC_DONE;
                end
                default:
                begin
                    state_d = rtucrc_pkg::RTUCRC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= rtucrc_pkg::RTUCRC_IDLE;
            cnt_q   <= '0;
            len_q   <= '0;
            rx_q    <= 1'b0;
            hi_q    <= 8'h00;
            out_q   <= 8'h00;
            done_q  <= 1'b0;
            ok_q    <= 1'b0;
            err_q   <= 1'b0;
            ovr_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            len_q   <= len_d;
            rx_q    <= rx_d;
            hi_q    <= hi_d;
            out_q   <= out_d;
            done_q  <= done_d;
            ok_q    <= ok_d;
            err_q   <= err_d;
            ovr_q   <= ovr_d;
        end
    end

    // check byte handshake; data held in a flop until taken
    always_comb
    begin
        chk_out.valid = (state_q == rtucrc_pkg::RTUCRC_CHK_LO) ||
                        (state_q == rtucrc_pkg::RTUCRC_CHK_HI);
        chk_out.data  = out_q;
    end

    always_comb
    begin
        status_out.done    = done_q;
        status_out.ok      = ok_q;
        status_out.err     = err_q;
        status_out.overrun = ovr_q;
        status_out.busy    = eng_busy;
    end

    // remainder and zero flag straight from the engine flops
    assign crc_out      = eng_crc;
    assign crc_zero_out = eng_zero;

endmodule // rtucrc_top

`default_nettype wire

// ### rtucrc_asserts.sv
// concurrent checks of the rtu crc-16 block at its ports
`timescale 1ns/1ps
`default_nettype none

module rtucrc_asserts
(
    input wire logic                     sys_clk_in,
    input wire logic                     rst_n_in,
    input wire logic                     preset_in,
    input wire rtucrc_pkg::rtucrc_byte_t byte_in,
    input wire logic                     byte_ready_out,
    input wire rtucrc_pkg::rtucrc_byte_t chk_out,
    input wire logic                     chk_ready_in,
    input wire logic [15:0]              crc_out,
    input wire logic                     crc_zero_out,
    input wire rtucrc_pkg::rtucrc_stat_t status_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_take;
        byte_in.valid && byte_ready_out && !preset_in;
    endsequence
    sequence s_steps;
        status_out.busy [*8] ##1 !status_out.busy;
    endsequence

    property p_preset;
        preset_in |=> crc_out == 16'hFFFF;
    endproperty
    property p_clear;
        preset_in |=> !status_out.ok && !status_out.err && !status_out.overrun;
    endproperty
    property p_load;
        s_take |=> crc_out == ($past(crc_out) ^ {8'h00, $past(byte_in.data)});
    endproperty
    // a preset inside the eight steps legally aborts them
    property p_steps;
        disable iff (!rst_n_in || preset_in) s_take |=> s_steps;
    endproperty
    property p_shift;
        status_out.busy && !preset_in |=> crc_out == (($past(crc_out) >> 1)
            ^ ($past(crc_out[0]) ? 16'hA001 : 16'h0000));
    endproperty
    property p_zero;
        crc_zero_out == (crc_out == 16'h0000);
    endproperty
    property p_hold;
        chk_out.valid && !chk_ready_in && !preset_in
            |=> chk_out.valid && $stable(chk_out.data);
    endproperty
    property p_verdict;
        status_out.done |-> status_out.ok != status_out.err
            && !(status_out.err && crc_zero_out);
    endproperty
    property p_done;
        status_out.done |=> !status_out.done;
    endproperty
    property p_sticky;
        status_out.overrun && !preset_in |=> status_out.overrun;
    endproperty
    property p_busy;
        status_out.busy |-> !byte_ready_out;
    endproperty

    a_preset: assert property (p_preset) else $error("crc not preset");
    a_clear: assert property (p_clear) else $error("flags not cleared");
    a_load: assert property (p_load) else $error("byte not combined");
    a_steps: assert property (p_steps) else $error("step count wrong");
    a_shift: assert property (p_shift) else $error("shift step wrong");
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    a_hold: assert property (p_hold) else $error("check byte moved");
    a_verdict: assert property (p_verdict) else $error("verdict wrong");
    a_done: assert property (p_done) else $error("done too long");
    a_sticky: assert property (p_sticky) else $error("overrun lost");
    a_busy: assert property (p_busy) else $error("ready while busy");
endmodule // rtucrc_asserts

bind rtucrc_top rtucrc_asserts u_asserts (.sys_clk_in, .rst_n_in, .preset_in,
    .byte_in, .byte_ready_out, .chk_out, .chk_ready_in, .crc_out,
    .crc_zero_out, .status_out);

`default_nettype wire

// ### rtucrc_framer.sv
// framer model: presets frames, offers bytes, takes check bytes
`timescale 1ns/1ps
`default_nettype none

module rtucrc_framer
(
    input  wire logic                     clk_in,
    input  wire logic                     slow_in,
    input  wire logic                     byte_ready_in,
    input  wire rtucrc_pkg::rtucrc_byte_t chk_in,
    output var  logic                     preset_out,
    output var  logic                     mode_rx_out,
    output var  logic [7:0]               len_out,
    output var  rtucrc_pkg::rtucrc_byte_t byte_out,
    output var  logic                     chk_ready_out
);
    logic [7:0] got[$];
    int         tick;

    initial
    begin
        preset_out = 1'b0;
        mode_rx_out = 1'b0;
        len_out = 8'h00;
        byte_out = 9'h0A5;
        chk_ready_out = 1'b0;
        tick = 0;
    end

    // slow framer takes a check byte only one cycle in three
    always @(negedge clk_in)
    begin
        tick <= tick + 1;
        chk_ready_out <= !slow_in || (tick % 3 == 0);
    end

    always @(posedge clk_in)
        if (chk_in.valid && chk_ready_out)
            got.push_back(chk_in.data);

    // tasks are entered at a falling edge and return at one
    task automatic start(input logic rx, input logic [7:0] n);
        preset_out = 1'b1;
        mode_rx_out = rx;
        len_out = n;
        @(negedge clk_in);
        preset_out = 1'b0;
        got.delete();
    endtask

    task automatic put_raw(input logic [7:0] d);
        byte_out = {1'b1, d};
        @(negedge clk_in);
        byte_out = {1'b0, ~d};
    endtask

    task automatic put_byte(input logic [7:0] d, output bit ok);
        ok = 1'b0;
        repeat (30)
        begin
            if (byte_ready_in === 1'b1)
            begin
                put_raw(d);
                ok = 1'b1;
                return;
            end
            @(negedge clk_in);
        end
    endtask
endmodule // rtucrc_framer

`default_nettype wire

// ### rtucrc_top_tb.sv
// self-checking bench of the crc-16 block against a byte model
`timescale 1ns/1ps
`default_nettype none

module rtucrc_top_tb;
    logic                     sys_clk_in = 1'b0;
    logic                     rst_n_in = 1'b0;
    logic                     slow = 1'b0;
    logic                     preset;
    logic                     mode_rx;
    logic [7:0]               len;
    rtucrc_pkg::rtucrc_byte_t bin;
    rtucrc_pkg::rtucrc_byte_t chk;
    logic                     byte_ready;
    logic                     chk_ready;
    logic [15:0]              crc;
    logic                     zero;
    rtucrc_pkg::rtucrc_stat_t st;
    logic [7:0]               q[$];
    logic [31:0]              seed = 32'h3606C23E;
    int                       err_count = 0;
    int                       compares = 0;

    always #2 sys_clk_in = ~sys_clk_in;

    rtucrc_top #(.LEN_W(8)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .preset_in(preset), .mode_rx_in(mode_rx), .data_len_in(len),
        .byte_in(bin), .byte_ready_out(byte_ready), .chk_out(chk),
        .chk_ready_in(chk_ready), .crc_out(crc), .crc_zero_out(zero),
        .status_out(st));

    rtucrc_framer fr (.clk_in(sys_clk_in), .slow_in(slow),
        .byte_ready_in(byte_ready), .chk_in(chk), .preset_out(preset),
        .mode_rx_out(mode_rx), .len_out(len), .byte_out(bin),
        .chk_ready_out(chk_ready));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [15:0] upd(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        repeat (8)
            c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        return c;
    endfunction

    task automatic give_verdict();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic hung();
        err_count++;
        give_verdict();
    endtask

    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        chk_val({15'h0000, g}, {15'h0000, e});
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 20 && st.busy !== 1'b0; i++)
            @(negedge sys_clk_in);
        if (i == 20)
            hung();
    endtask

    task automatic frame(input logic rx, input logic bad);
        logic [15:0] c;
        logic [15:0] x;
        bit          ok;
        int          i;
        int          n;
        n = q.size();
        x = 16'hFFFF;
        foreach (q[j])
            x = upd(x, q[j]);
        if (rx)
        begin
            q.push_back(x[7:0] ^ {7'h00, bad});
            q.push_back(x[15:8]);
        end
        c = 16'hFFFF;
        fr.start(rx, 8'(n));
        chk_val(crc, c);
        chk_bit(byte_ready, rx || n != 0);
        foreach (q[j])
        begin
            fr.put_byte(q[j], ok);
            if (!ok)
                hung();
            c = upd(c, q[j]);
            wait_idle();
            chk_val(crc, c);
            chk_bit(zero, c == 16'h0000);
        end
        for (i = 0; i < 80 && st.done !== 1'b1; i++)
            @(negedge sys_clk_in);
        if (i == 80)
            hung();
        chk_bit(st.ok, !rx || c == 16'h0000);
        chk_bit(st.err, rx && c != 16'h0000);
        chk_bit(byte_ready, 1'b0);
        if (!rx)
        begin
            chk_val(16'(fr.got.size()), 16'h0002);
            chk_val({8'h00, fr.got[0]}, {8'h00, x[7:0]});
            chk_val({8'h00, fr.got[1]}, {8'h00, x[15:8]});
        end
    endtask

    initial
    begin
        int          k;
        logic [31:0] r;
        bit          ok;
        repeat (5) @(negedge sys_clk_in);
        chk_val(crc, 16'hFFFF);
        rst_n_in = 1'b1;
        slow = 1'b1;
        q = '{8'h01, 8'h07};
        frame(1'b0, 1'b0);
        q = '{8'h01, 8'h07};
        frame(1'b1, 1'b0);
        q = '{8'h01, 8'h07};
        frame(1'b1, 1'b1);
        q.delete();
        frame(1'b0, 1'b0);
        // a byte offered mid-shift must be dropped, not merged
        fr.start(1'b0, 8'h03);
        fr.put_byte(8'h11, ok);
        if (!ok)
            hung();
        @(negedge sys_clk_in);
        fr.put_raw(8'h55);
        wait_idle();
        chk_val(crc, upd(16'hFFFF, 8'h11));
        chk_bit(st.overrun, 1'b1);
        fr.start(1'b1, 8'h01);
        chk_val(crc, 16'hFFFF);
        chk_bit(st.overrun, 1'b0);
        // reset in mid-shift; the idle block then ignores strobes
        fr.put_byte(8'h3C, ok);
        if (!ok)
            hung();
        @(negedge sys_clk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        chk_val(crc, 16'hFFFF);
        chk_val({11'h000, st}, 16'h0000);
        chk_bit(byte_ready || chk.valid, 1'b0);
        rst_n_in = 1'b1;
        fr.put_raw(8'h5A);
        chk_bit(st.overrun, 1'b0);
        chk_val(crc, 16'hFFFF);
        for (k = 0; k < 12; k++)
        begin
            q.delete();
            r = rnd();
            repeat (r % 6) q.push_back(8'(rnd()));
            slow = r[8];
            frame(r[9], r[10]);
        end
        give_verdict();
    end
endmodule // rtucrc_top_tb

`default_nettype wire
